// >>> core/lcsr_pkg.sv
// constants, carriers and states for the led current setting registers
// assumes one 200 MHz clock and a synchronous active-high reset
//
// Notes on behaviour
// - bit 7 of the first flash register turns channel one on in flash mode, reset value 0x29.
// - channel one flash enable drops on lockout, low logic supply or a led one fault in flash.
// - flash level bits 5..0 step 15.625mA from code 0, default 101001, bit 6 reads zero.
// - second flash register holds enable in bit 7, zero in bit 6, level in 5..0, reset 0x29.
// - channel two flash enable drops on lockout, low logic supply or a led two fault in flash.
// - bit 7 of the torch register turns channel one on in torch mode, reset value 0x00.
// - channel one torch enable drops on lockout, low logic supply or a led one fault in torch.
// - torch bit 0 picks dac level control when clear and pwm dimming when set.
// - in dac dimming the six-bit torch field steps about 3.91mA per code, default zero.
// - in pwm dimming the low three field bits give pulse current 125mA to 1000mA.
// - in pwm dimming the high three field bits give duty 3.125% to 25% in 3.125% steps.
package lcsr_pkg;
	// =========================================
	// register map
	localparam logic [7:0] LCSR_OFF_FLASH1 = 8'h04;
	localparam logic [7:0] LCSR_OFF_FLASH2 = 8'h05;
	localparam logic [7:0] LCSR_OFF_TORCH1 = 8'h06;
	localparam logic [7:0] LCSR_RST_FLASH = 8'h29;
	localparam logic [7:0] LCSR_RST_TORCH = 8'h00;
	localparam int LCSR_EN_BIT = 7;
	localparam int LCSR_RSV_BIT = 6;
	localparam int LCSR_DIM_BIT = 0;
	localparam logic [6:0] LCSR_DEV_ADDR = 7'h3A;
	localparam logic [3:0] LCSR_BITS_PER_BYTE = 4'h8;
	// =========================================
	// synchroniser lanes
	localparam int LCSR_SY_SCL = 0;
	localparam int LCSR_SY_SDA = 1;
	localparam int LCSR_SY_UNDERVOLTAGE_LOCKOUT = 2;
	localparam int LCSR_SY_VDDLO = 3;
	localparam int LCSR_SY_F1 = 4;
	localparam int LCSR_SY_F2 = 5;
	localparam int LCSR_SY_FMODE = 6;
	localparam int LCSR_SY_TMODE = 7;
	localparam int LCSR_SY_N = 8;
	// =========================================
	// serial slave states
	typedef enum logic [8:0] {
		LCSR_IDLE = 9'h001,
		LCSR_ADDR = 9'h002,
		LCSR_ACKA = 9'h004,
		LCSR_PTR = 9'h008,
		LCSR_ACKP = 9'h010,
		LCSR_WDAT = 9'h020,
		LCSR_ACKW = 9'h040,
		LCSR_RDAT = 9'h080,
		LCSR_RACK = 9'h100
	} lcsr_st_t;
	typedef struct packed {
		logic [7:0] fl1;
		logic [7:0] fl2;
		logic [7:0] tor;
	} lcsr_regs_t;
	typedef struct packed {
		lcsr_regs_t regs;
		lcsr_st_t st;
		logic [7:0] ptr;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic rw;
		logic nack;
		logic sda_oe;
		logic [LCSR_SY_N-1:0] sync1;
		logic [LCSR_SY_N-1:0] sync2;
		logic scl_d;
		logic sda_d;
	} lcsr_state_t;
endpackage

// >>> core/lcsr_top.sv
// led current setting registers behind a two-wire serial slave
// assumes scl, sda and fault pins asynchronous; sda pin is open drain
`timescale 1ns/1ps
module lcsr_top import lcsr_pkg::*; (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	input wire logic UNDERVOLTAGE_LOCKOUT_IN,
	input wire logic LOGIC_SUPPLY_LOW_IN,
	input wire logic LED1_FAULT_IN,
	input wire logic LED2_FAULT_IN,
	input wire logic FLASH_MODE_IN,
	input wire logic TORCH_MODE_IN,
	output logic CH1_FLASH_ENABLE_OUT,
	output logic [5:0] CH1_FLASH_LEVEL_OUT,
	output logic CH2_FLASH_ENABLE_OUT,
	output logic [5:0] CH2_FLASH_LEVEL_OUT,
	output logic CH1_TORCH_ENABLE_OUT,
	output logic CH1_TORCH_DIM_SELECT_OUT,
	output logic [5:0] CH1_TORCH_LEVEL_OUT
);
	// =========================================
	// state
	lcsr_state_t s_q;
	lcsr_state_t s_d;
	logic scl;
	logic sda;
	logic start;
	logic stop;
	logic rise;
	logic fall;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic supply_bad;
	logic kill_f1;
	logic kill_f2;
	logic kill_t1;

	function automatic logic [7:0] rd_reg(input lcsr_regs_t r, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			LCSR_OFF_FLASH1: v = r.fl1;
			LCSR_OFF_FLASH2: v = r.fl2;
			LCSR_OFF_TORCH1: v = r.tor;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// =========================================
	// next state
	always_comb begin
		s_d = s_q;
		scl = s_q.sync2[LCSR_SY_SCL];
		sda = s_q.sync2[LCSR_SY_SDA];
		start = s_q.scl_d & scl & s_q.sda_d & ~sda;
		stop = s_q.scl_d & scl & ~s_q.sda_d & sda;
		rise = ~s_q.scl_d & scl;
		fall = s_q.scl_d & ~scl;
		wr_en = 1'b0;
		wr_addr = s_q.ptr;
		wr_data = s_q.sh;
		supply_bad = s_q.sync2[LCSR_SY_UNDERVOLTAGE_LOCKOUT] | s_q.sync2[LCSR_SY_VDDLO];
		kill_f1 = supply_bad | (s_q.sync2[LCSR_SY_F1] & s_q.sync2[LCSR_SY_FMODE]);
		kill_f2 = supply_bad | (s_q.sync2[LCSR_SY_F2] & s_q.sync2[LCSR_SY_FMODE]);
		kill_t1 = supply_bad | (s_q.sync2[LCSR_SY_F1] & s_q.sync2[LCSR_SY_TMODE]);
		s_d.sync1 = {TORCH_MODE_IN, FLASH_MODE_IN, LED2_FAULT_IN, LED1_FAULT_IN,
			LOGIC_SUPPLY_LOW_IN, UNDERVOLTAGE_LOCKOUT_IN, SDA_IN, SCL_IN};
		s_d.sync2 = s_q.sync1;
		s_d.scl_d = scl;
		s_d.sda_d = sda;
		if (start) begin
			s_d.st = LCSR_ADDR;
			s_d.cnt = 4'h0;
			s_d.sda_oe = 1'b0;
		end else if (stop) begin
			s_d.st = LCSR_IDLE;
			s_d.sda_oe = 1'b0;
		end else if (rise) begin
			if (s_q.st inside {LCSR_ADDR, LCSR_PTR, LCSR_WDAT}) begin
				s_d.sh = {s_q.sh[6:0], sda};
				s_d.cnt = s_q.cnt + 4'h1;
			end else if (s_q.st == LCSR_RDAT) begin
				s_d.cnt = s_q.cnt + 4'h1;
			end else if (s_q.st == LCSR_RACK) begin
				s_d.nack = sda;
			end
		end else if (fall) begin
			unique case (s_q.st)
				LCSR_IDLE: s_d.sda_oe = 1'b0;
				LCSR_ADDR: begin
					if (s_q.cnt == LCSR_BITS_PER_BYTE) begin
						if (s_q.sh[7:1] == LCSR_DEV_ADDR) begin
							s_d.st = LCSR_ACKA;
							s_d.rw = s_q.sh[0];
							s_d.sda_oe = 1'b1;
						end else begin
							s_d.st = LCSR_IDLE;
						end
					end
				end
				LCSR_ACKA: begin
					s_d.cnt = 4'h0;
					if (s_q.rw) begin
						s_d.sh = rd_reg(s_q.regs, s_q.ptr);
						s_d.ptr = s_q.ptr + 8'h01;
						s_d.sda_oe = ~s_d.sh[7];
						s_d.st = LCSR_RDAT;
					end else begin
						s_d.sda_oe = 1'b0;
						s_d.st = LCSR_PTR;
					end
				end
				LCSR_PTR: begin
					if (s_q.cnt == LCSR_BITS_PER_BYTE) begin
						s_d.ptr = s_q.sh;
						s_d.sda_oe = 1'b1;
						s_d.st = LCSR_ACKP;
					end
				end
				LCSR_WDAT: begin
					if (s_q.cnt == LCSR_BITS_PER_BYTE) begin
						wr_en = 1'b1;
						s_d.ptr = s_q.ptr + 8'h01;
						s_d.sda_oe = 1'b1;
						s_d.st = LCSR_ACKW;
					end
				end
				LCSR_ACKP, LCSR_ACKW: begin
					s_d.cnt = 4'h0;
					s_d.sda_oe = 1'b0;
					s_d.st = LCSR_WDAT;
				end
				LCSR_RDAT: begin
					if (s_q.cnt == LCSR_BITS_PER_BYTE) begin
						s_d.sda_oe = 1'b0;
						s_d.st = LCSR_RACK;
					end else begin
						s_d.sh = {s_q.sh[6:0], 1'b0};
						s_d.sda_oe = ~s_q.sh[6];
					end
				end
				LCSR_RACK: begin
					s_d.cnt = 4'h0;
					if (s_q.nack) begin
						s_d.st = LCSR_IDLE;
						s_d.sda_oe = 1'b0;
					end else begin
						s_d.sh = rd_reg(s_q.regs, s_q.ptr);
						s_d.ptr = s_q.ptr + 8'h01;
						s_d.sda_oe = ~s_d.sh[7];
						s_d.st = LCSR_RDAT;
					end
				end
			endcase
		end
		// register writes, reserved bit held at zero
		if (wr_en) begin
			unique case (wr_addr)
				LCSR_OFF_FLASH1: s_d.regs.fl1 = wr_data & 8'hBF;
				LCSR_OFF_FLASH2: s_d.regs.fl2 = wr_data & 8'hBF;
				LCSR_OFF_TORCH1: s_d.regs.tor = wr_data;
				default: s_d.regs = s_q.regs;
			endcase
		end
		// faults drop enables only, and win over a same-cycle write
		if (kill_f1) begin
			s_d.regs.fl1[LCSR_EN_BIT] = 1'b0;
		end
		if (kill_f2) begin
			s_d.regs.fl2[LCSR_EN_BIT] = 1'b0;
		end
		if (kill_t1) begin
			s_d.regs.tor[LCSR_EN_BIT] = 1'b0;
		end
	end

	// =========================================
	// registers
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			s_q <= '0;
			s_q.st <= LCSR_IDLE;
			s_q.regs.fl1 <= LCSR_RST_FLASH;
			s_q.regs.fl2 <= LCSR_RST_FLASH;
			s_q.regs.tor <= LCSR_RST_TORCH;
			s_q.sync1 <= 8'h03;
			s_q.sync2 <= 8'h03;
			s_q.scl_d <= 1'b1;
			s_q.sda_d <= 1'b1;
		end else if (CE_IN) begin
			s_q <= s_d;
		end
	end

	// =========================================
	// outputs
	assign SDA_OUT = 1'b0;
	assign SDA_OE_OUT = s_q.sda_oe;
	assign CH1_FLASH_ENABLE_OUT = s_q.regs.fl1[LCSR_EN_BIT];
	assign CH1_FLASH_LEVEL_OUT = s_q.regs.fl1[5:0];
	assign CH2_FLASH_ENABLE_OUT = s_q.regs.fl2[LCSR_EN_BIT];
	assign CH2_FLASH_LEVEL_OUT = s_q.regs.fl2[5:0];
	assign CH1_TORCH_ENABLE_OUT = s_q.regs.tor[LCSR_EN_BIT];
	assign CH1_TORCH_DIM_SELECT_OUT = s_q.regs.tor[LCSR_DIM_BIT];
	assign CH1_TORCH_LEVEL_OUT = s_q.regs.tor[6:1];

	// =========================================
	// checks
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);

	chk_flash1_reset: assert property (disable iff (1'b0)
		RST_IN |=> s_q.regs.fl1 == LCSR_RST_FLASH)
		else $error("flash one reset value wrong");
	chk_flash1_kill: assert property (CE_IN && kill_f1 |=> !CH1_FLASH_ENABLE_OUT)
		else $error("flash one enable survived a fault");
	chk_flash1_rsv: assert property (s_q.regs.fl1[LCSR_RSV_BIT] == 1'b0)
		else $error("flash one reserved bit set");
	chk_flash2_rsv: assert property (s_q.regs.fl2[LCSR_RSV_BIT] == 1'b0)
		else $error("flash two reserved bit set");
	chk_flash2_kill: assert property (CE_IN && kill_f2 |=> !CH2_FLASH_ENABLE_OUT)
		else $error("flash two enable survived a fault");
	chk_torch_write: assert property (
		CE_IN && wr_en && wr_addr == LCSR_OFF_TORCH1 && !kill_t1
		|=> CH1_TORCH_ENABLE_OUT == $past(wr_data[7]))
		else $error("torch enable not written");
	chk_torch_kill: assert property (CE_IN && kill_t1 |=> !CH1_TORCH_ENABLE_OUT)
		else $error("torch enable survived a fault");
	chk_dim_write: assert property (CE_IN && wr_en && wr_addr == LCSR_OFF_TORCH1
		|=> CH1_TORCH_DIM_SELECT_OUT == $past(wr_data[0]))
		else $error("dim select not written");
	chk_torch_field: assert property (
		CE_IN && wr_en && wr_addr == LCSR_OFF_TORCH1
		|=> CH1_TORCH_LEVEL_OUT == $past(wr_data[6:1]))
		else $error("torch field not written");
	chk_kill_keeps: assert property (CE_IN && !wr_en && (kill_f1 || kill_t1)
		|=> $stable(CH1_FLASH_LEVEL_OUT) && $stable(CH1_TORCH_LEVEL_OUT)
		&& $stable(CH1_TORCH_DIM_SELECT_OUT))
		else $error("fault disturbed a level field");
	chk_frozen: assert property (!CE_IN |=> $stable(s_q.regs))
		else $error("state moved with clock enable low");

	cov_flash_write: cover property (wr_en && wr_addr == LCSR_OFF_FLASH1);
	cov_read_byte: cover property (s_q.st == LCSR_RDAT ##1 s_q.st == LCSR_RACK);
	cov_torch_kill: cover property (CH1_TORCH_ENABLE_OUT ##1 !CH1_TORCH_ENABLE_OUT);
endmodule

// >>> dv/lcsr_top_tb.sv
// self-checking bench for the led current setting registers
// assumes the two-wire pins are bit-banged here; sda wire pulled up, open drain
`timescale 1ns/1ps
module lcsr_top_tb import lcsr_pkg::*; ;
	// =========================================
	// signals
	logic clk;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic scl = 1'b1;
	logic sdam = 1'b1;
	logic [5:0] flt = 6'h00;
	logic oe, sdo, f1e, f2e, te, td;
	logic [5:0] f1l, f2l, tl;
	logic [7:0] m [3];
	logic [23:0] r, v;
	logic a;
	int bad_count = 0;
	int tests_run = 0;
	int seed;
	logic [5:0] ftab [6] = '{6'h20, 6'h10, 6'h0A, 6'h09, 6'h06, 6'h0C};
	logic [2:0] ctab [6] = '{3'h7, 3'h7, 3'h4, 3'h1, 3'h2, 3'h0};
	wire sda = sdam & ~oe;
	wire [21:0] got_o = {f1e, f1l, f2e, f2l, te, td, tl};
	lcsr_top dut (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(ce), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sdo), .SDA_OE_OUT(oe), .UNDERVOLTAGE_LOCKOUT_IN(flt[5]),
		.LOGIC_SUPPLY_LOW_IN(flt[4]), .LED1_FAULT_IN(flt[3]), .LED2_FAULT_IN(flt[2]),
		.FLASH_MODE_IN(flt[1]), .TORCH_MODE_IN(flt[0]), .CH1_FLASH_ENABLE_OUT(f1e),
		.CH1_FLASH_LEVEL_OUT(f1l), .CH2_FLASH_ENABLE_OUT(f2e), .CH2_FLASH_LEVEL_OUT(f2l),
		.CH1_TORCH_ENABLE_OUT(te), .CH1_TORCH_DIM_SELECT_OUT(td), .CH1_TORCH_LEVEL_OUT(tl));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// =========================================
	// helpers
	function automatic logic [21:0] exp_o();
		return {m[0][7], m[0][5:0], m[1][7], m[1][5:0], m[2][7], m[2][0], m[2][6:1]};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic check(input logic [23:0] g, input logic [23:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches=%0d checks=%0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// =========================================
	// two-wire master
	task automatic bit_io(input logic b, output logic q);
		scl <= 1'b0;
		cyc(2);
		sdam <= b;
		cyc(6);
		scl <= 1'b1;
		cyc(4);
		q = sda;
		cyc(4);
	endtask
	task automatic start_c();
		scl <= 1'b0;
		cyc(4);
		sdam <= 1'b1;
		cyc(4);
		scl <= 1'b1;
		cyc(8);
		sdam <= 1'b0;
		cyc(8);
	endtask
	task automatic stop_c();
		scl <= 1'b0;
		cyc(4);
		sdam <= 1'b0;
		cyc(4);
		scl <= 1'b1;
		cyc(8);
		sdam <= 1'b1;
		cyc(8);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic q;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q);
		bit_io(1'b1, ack);
	endtask
	task automatic wr(input logic [7:0] p, input logic [23:0] d, input int n);
		logic k;
		start_c();
		wbyte({LCSR_DEV_ADDR, 1'b0}, k);
		check(24'(k), 24'h0);
		wbyte(p, k);
		check(24'(k), 24'h0);
		for (int i = 0; i < n; i++) begin
			wbyte(d[23-8*i -: 8], k);
			check(24'(k), 24'h0);
		end
		stop_c();
	endtask
	task automatic rd(input logic [7:0] p, input int n, output logic [23:0] d);
		logic k;
		d = 24'h0;
		start_c();
		wbyte({LCSR_DEV_ADDR, 1'b0}, k);
		wbyte(p, k);
		start_c();
		wbyte({LCSR_DEV_ADDR, 1'b1}, k);
		check(24'(k), 24'h0);
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) bit_io(1'b1, d[23-8*i-(7-j)]);
			bit_io(i == n - 1, k);
		end
		stop_c();
	endtask
	// =========================================
	// main sequence
	initial begin
		seed = 32'hAB65;
		cyc(5);
		rst <= 1'b0;
		cyc(4);
		m[0] = 8'h29;
		m[1] = 8'h29;
		m[2] = 8'h00;
		check(24'(got_o), 24'(exp_o()));
		rd(8'h04, 3, r);
		check(r, 24'h292900);
		for (int k = 0; k < 8; k++) begin
			v = 24'($random(seed));
			if (k == 0) v = 24'hFFFFFF;
			if (k == 1) v = 24'h000000;
			if (k == 2) v = 24'h40BF85;
			m[0] = v[23:16] & 8'hBF;
			m[1] = v[15:8] & 8'hBF;
			m[2] = v[7:0];
			wr(8'h04, v, 3);
			check(24'(got_o), 24'(exp_o()));
			rd(8'h04, 3, r);
			check(r, {m[0], m[1], m[2]});
		end
		wr(8'h10, 24'h5A0000, 1);
		rd(8'h10, 1, r);
		check(r, 24'h0);
		check(24'(got_o), 24'(exp_o()));
		start_c();
		wbyte({LCSR_DEV_ADDR ^ 7'h01, 1'b0}, a);
		check(24'(a), 24'h1);
		wbyte(8'h04, a);
		check(24'(a), 24'h1);
		stop_c();
		for (int k = 0; k < 6; k++) begin
			wr(8'h04, 24'hFFFFFF, 3);
			m[0] = 8'hBF;
			m[1] = 8'hBF;
			m[2] = 8'hFF;
			flt <= ftab[k];
			cyc(8);
			flt <= 6'h00;
			cyc(4);
			m[0][7] = ~ctab[k][2];
			m[1][7] = ~ctab[k][1];
			m[2][7] = ~ctab[k][0];
			check(24'(got_o), 24'(exp_o()));
			rd(8'h04, 3, r);
			check(r, {m[0], m[1], m[2]});
		end
		// frozen clock enable must swallow a lockout pulse
		ce <= 1'b0;
		flt <= 6'h20;
		cyc(8);
		flt <= 6'h00;
		cyc(4);
		ce <= 1'b1;
		cyc(4);
		check(24'(got_o), 24'(exp_o()));
		check(24'(sdo), 24'h0);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(4);
		m[0] = 8'h29;
		m[1] = 8'h29;
		m[2] = 8'h00;
		check(24'(got_o), 24'(exp_o()));
		rd(8'h04, 3, r);
		check(r, 24'h292900);
		report_and_stop();
	end
	// =========================================
	// watchdog
	initial begin
		cyc(90000);
		bad_count++;
		report_and_stop();
	end
endmodule
